//--- hdl/adc_lvds_serial_readout.sv
// device-side conversion start handling and serial result readout
`timescale 1ns/1ps
module adc_lvds_serial_readout #(
   parameter int MSB_CYC = adc_readout_pkg::FIRST_BIT_DELAY_CYC,
   parameter int CLKL_CYC = adc_readout_pkg::BURST_DEADLINE_CYC,
   parameter int STRAP_CYC = adc_readout_pkg::STRAP_SETTLE_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link pins from the host
   input wire logic conv_start,
   input wire logic host_clk,
   // code from the converter core
   input wire logic [15:0] sample_code,
   // link pins to the host, plus the echo pin read back for the mode strap
   output logic serial_data_out,
   input wire logic echo_clk_in,
   output logic echoed_clock_out,
   output logic echo_clk_oe_n,
   // status
   output logic conv_busy,
   output logic self_clocked
);
   // ==========================================================
   // pin synchronisers: bit 0 start, bit 1 burst clock, bit 2 strap
   logic [2:0] sync_s1_r;
   logic [2:0] sync_s2_r;
   logic start_d_r;
   logic hclk_d_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_s1_r <= adc_readout_pkg::SYNC_RESET;
         sync_s2_r <= adc_readout_pkg::SYNC_RESET;
         start_d_r <= 1'h0;
         hclk_d_r <= 1'h0;
      end else begin
         sync_s1_r <= {echo_clk_in, host_clk, conv_start};
         sync_s2_r <= sync_s1_r;
         start_d_r <= sync_s2_r[0];
         hclk_d_r <= sync_s2_r[1];
      end
   end

   wire start_edge = sync_s2_r[0] && !start_d_r;
   wire hclk_fall = !sync_s2_r[1] && hclk_d_r;
   // each pin edge costs three core edges, so the burst clock must stay well below core rate

   // ==========================================================
   // mode strap: pin is released until the strap is read once after reset
   logic [3:0] strap_cnt_r;
   logic strap_done_r;
   logic self_clocked_r;
   logic oe_n_r;
   wire strap_take = !strap_done_r && (strap_cnt_r == 4'(STRAP_CYC));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_r <= 4'h0;
         strap_done_r <= 1'h0;
         self_clocked_r <= 1'h0;
         oe_n_r <= 1'h1;
      end else if (strap_take) begin
         strap_done_r <= 1'h1;
         self_clocked_r <= !sync_s2_r[2];
         oe_n_r <= !sync_s2_r[2];
      end else if (!strap_done_r) begin
         strap_cnt_r <= strap_cnt_r + 4'h1;
      end
   end

   // ==========================================================
   // conversion timing
   logic busy_w;
   logic burst_hold;
   logic frame_load;
   logic [15:0] result_code;

   conv_timer #(
      .MSB_CYC(MSB_CYC),
      .CLKL_CYC(CLKL_CYC)
   ) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(start_edge),
      .sample_code(sample_code),
      .busy_r(busy_w),
      .clkl_hit_r(burst_hold),
      .done_r(frame_load),
      .code_r(result_code)
   );

   // ==========================================================
   // output frame
   // echoed mode pads two zeros below the result instead of a header
   logic [17:0] frame_r;
   logic echo_en_r;
   logic echo_out_r;
   logic busy_r;

   wire [17:0] frame_loaded = self_clocked_r ?
      {adc_readout_pkg::HEADER_CODE, result_code} : {result_code, 2'h0};
   wire zero_hold = burst_hold && !self_clocked_r;
   wire [17:0] frame_nxt = frame_load ? frame_loaded :
      zero_hold ? 18'h0_0000 :
      hclk_fall ? {frame_r[16:0], 1'h0} : frame_r;
   wire echo_en_nxt = (frame_load && !self_clocked_r) ? 1'h1 :
      zero_hold ? 1'h0 : echo_en_r;
   // echo follows the synchronised clock so it changes on the same edge as data
   wire echo_out_nxt = echo_en_nxt && !self_clocked_r && sync_s2_r[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_r <= 18'h0_0000;
         echo_en_r <= 1'h0;
         echo_out_r <= 1'h0;
         busy_r <= 1'h0;
      end else begin
         frame_r <= frame_nxt;
         echo_en_r <= echo_en_nxt;
         echo_out_r <= echo_out_nxt;
         busy_r <= busy_w;
      end
   end

   assign serial_data_out = frame_r[17];
   assign echoed_clock_out = echo_out_r;
   assign echo_clk_oe_n = oe_n_r;
   assign conv_busy = busy_r;
   assign self_clocked = self_clocked_r;

   // ==========================================================
   // header tracking for the checks
   // high from a load until the first shift after it, however late the host starts
   logic hdr_wait_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hdr_wait_r <= 1'h0;
      end else begin
         hdr_wait_r <= frame_load || (hdr_wait_r && !hclk_fall);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   start_rise_a: assert property (start_edge && !busy_w |=> busy_w)
      else $error("rising start did not begin a conversion");
   // the repeat count follows the default conversion length of five cycles
   run_complete_a: assert property ($rose(busy_w) |-> busy_w[*5] ##1 !busy_w)
      else $error("conversion did not run its full length");
   ignore_start_a: assert property (start_edge && busy_w |=> !$rose(busy_w))
      else $error("start during conversion restarted it");
   busy_follow_a: assert property (busy_r == $past(busy_w))
      else $error("busy output does not follow the conversion");
   load_at_end_a: assert property (frame_load |-> !busy_w && $past(busy_w))
      else $error("result loaded outside a conversion end");
   echo_replica_a: assert property (!self_clocked_r && echo_en_r && $past(echo_en_r)
      |-> echo_out_r == $past(sync_s2_r[1]))
      else $error("echoed clock does not follow burst clock");
   data_on_fall_a: assert property (!self_clocked_r && $changed(frame_r[17])
      && !$past(frame_load) && !$past(zero_hold) |-> $past(hclk_fall))
      else $error("data changed away from a falling edge");
   zero_hold_a: assert property (zero_hold |=> (!frame_r[17] && !echo_out_r)
      until frame_load)
      else $error("outputs not held low before first bit");
   hold_bound_a: assert property (burst_hold |-> ##[1:8] frame_load)
      else $error("zero window did not end");
   echo_idle_a: assert property (!echo_en_r && !frame_load |=> !echo_out_r)
      else $error("echoed clock driven outside a frame");
   header_first_a: assert property (self_clocked_r && frame_load
      |=> frame_r[17] == adc_readout_pkg::HEADER_CODE[1])
      else $error("first header bit missing");
   header_second_a: assert property (self_clocked_r && hdr_wait_r && hclk_fall
      && !frame_load |=> frame_r[17] == adc_readout_pkg::HEADER_CODE[0])
      else $error("second header bit missing");
   self_shift_a: assert property (self_clocked_r && hclk_fall && !frame_load
      |=> frame_r[17] == $past(frame_r[16]))
      else $error("self-clocked data did not move on a falling edge");
   msb_first_a: assert property (!self_clocked_r && frame_load
      |=> frame_r[17] == $past(result_code[15]))
      else $error("result not msb first");
   strap_mode_a: assert property (self_clocked_r |-> oe_n_r && !echo_out_r)
      else $error("echo pin driven in self-clocked mode");
   strap_fixed_a: assert property (strap_done_r |=> $stable(self_clocked_r))
      else $error("readout mode changed after the strap");
   oe_held_a: assert property (!strap_done_r |-> oe_n_r)
      else $error("echo pin driven before the strap was read");

   echoed_read_c: cover property (!self_clocked_r && frame_load ##[1:200] hclk_fall);
   self_read_c: cover property (self_clocked_r && frame_load ##[1:200] hclk_fall);
   busy_start_c: cover property (start_edge && busy_w);
   zero_window_c: cover property (zero_hold ##[1:8] frame_load);
   header_shift_c: cover property (self_clocked_r && hdr_wait_r && hclk_fall);
endmodule

//--- hdl/adc_readout_pkg.sv
// shared constants for the serial result readout of the converter
package adc_readout_pkg;
   // ==========================================================
   // clock and link timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int FIRST_BIT_DELAY_NS = 100;
   localparam int CLOCK_BURST_DEADLINE_NS = 40;
   // a longest time rounds down, never below one cycle
   localparam int FIRST_BIT_DELAY_CYC =
      (FIRST_BIT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : (FIRST_BIT_DELAY_NS / CLK_PERIOD_NS);
   // the deadline rounds up so the zero window never opens early
   localparam int BURST_DEADLINE_CYC =
      (CLOCK_BURST_DEADLINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // word layout
   localparam int RESULT_BITS = 16;
   localparam int HEADER_BITS = 2;
   localparam int FRAME_BITS = RESULT_BITS + HEADER_BITS;
   localparam logic [1:0] HEADER_CODE = 2'h2;
   // ==========================================================
   // mode strap
   localparam int STRAP_SETTLE_CYC = 4;
   localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

//--- hdl/conv_timer.sv
// conversion timer: runs one conversion to its end and captures the code
`timescale 1ns/1ps
module conv_timer #(
   parameter int MSB_CYC = adc_readout_pkg::FIRST_BIT_DELAY_CYC,
   parameter int CLKL_CYC = adc_readout_pkg::BURST_DEADLINE_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [15:0] sample_code,
   // status
   output logic busy_r,
   output logic clkl_hit_r,
   output logic done_r,
   output logic [15:0] code_r
);
   logic [7:0] cnt_r;
   wire go = start && !busy_r;
   wire at_clkl = busy_r && (cnt_r == 8'(CLKL_CYC));
   wire at_end = busy_r && (cnt_r == 8'(MSB_CYC));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'h0;
         cnt_r <= 8'h00;
         clkl_hit_r <= 1'h0;
         done_r <= 1'h0;
         code_r <= 16'h0000;
      end else begin
         clkl_hit_r <= at_clkl;
         done_r <= at_end;
         // once started, the count runs out whatever start does
         if (go) begin
            busy_r <= 1'h1;
            cnt_r <= 8'h01;
         end else if (at_end) begin
            busy_r <= 1'h0;
            code_r <= sample_code;
         end else if (busy_r) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule

//--- testbench/host_model.sv
// host side model: start pulses, clock bursts and bit capture
`timescale 1ns/1ps
module host_model #(
   parameter int HALF_CYC = 4
) (
   // clock and mode
   input wire logic core_clk,
   input wire logic self_mode,
   // link pins
   input wire logic echo_pin,
   input wire logic serial_data_out,
   output logic conv_start,
   output logic host_clk
);
   // one capture register per mode, so each has a single writer
   logic [15:0] cap_echo_r = 16'h0000;
   logic [17:0] cap_self_r = 18'h0_0000;
   initial begin
      conv_start = 1'b0;
      host_clk = 1'b0;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // the level comes as an argument: the mode port may not have settled yet
   task automatic park(input logic lvl);
      host_clk = lvl;
   endtask
   // the second edge lands while the first conversion still runs
   task automatic start(input bit twice);
      conv_start = 1'b1;
      wait_cyc(3);
      conv_start = 1'b0;
      if (twice) begin
         wait_cyc(1);
         conv_start = 1'b1;
         wait_cyc(2);
         conv_start = 1'b0;
      end
      wait_cyc(12);
   endtask
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         host_clk = !self_mode;
         wait_cyc(HALF_CYC);
         host_clk = self_mode;
         wait_cyc(HALF_CYC);
      end
   endtask
   always @(posedge echo_pin) if (!self_mode) cap_echo_r <= {cap_echo_r[14:0], serial_data_out};
   // self-clocked: take the old bit at the fall, before the device moves on
   always @(negedge host_clk) if (self_mode) cap_self_r <= {cap_self_r[16:0], serial_data_out};
endmodule

//--- testbench/tb_top.sv
// self-checking bench: both readout modes against the host model
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] sample_code = 16'h0000;
   logic pull_lvl = 1'b1;
   logic self_exp = 1'b0;
   wire logic conv_start;
   wire logic host_clk;
   wire logic echo_pin;
   logic serial_data_out, echoed_clock_out, echo_clk_oe_n, conv_busy, self_clocked;
   int num_errors = 0;
   int compares = 0;
   int busy_cnt = 0;
   logic [31:0] rng = 32'h0000_adce;
   always #10 core_clk = ~core_clk;
   // pin level: device drive when enabled, else the board pull
   assign echo_pin = !echo_clk_oe_n ? echoed_clock_out : pull_lvl;
   adc_lvds_serial_readout dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .conv_start(conv_start), .host_clk(host_clk), .sample_code(sample_code),
      .serial_data_out(serial_data_out), .echo_clk_in(echo_pin),
      .echoed_clock_out(echoed_clock_out), .echo_clk_oe_n(echo_clk_oe_n),
      .conv_busy(conv_busy), .self_clocked(self_clocked));
   host_model host_u (.core_clk(core_clk), .self_mode(self_exp), .echo_pin(echo_pin),
      .serial_data_out(serial_data_out), .conv_start(conv_start), .host_clk(host_clk));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [17:0] frame_of(input logic self, input logic [15:0] c);
      return self ? {adc_readout_pkg::HEADER_CODE, c} : {2'h0, c};
   endfunction
   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (conv_busy) begin
         if (!self_clocked && busy_cnt >= 2 && busy_cnt <= 4)
            check("zero hold", 18'h0_0000, {16'h0000, serial_data_out, echoed_clock_out});
         busy_cnt++;
      end else if (busy_cnt != 0) begin
         check("busy length", 18'h0_0005, 18'(busy_cnt));
         busy_cnt = 0;
      end
   end
   // k 2 reads only half a word in echoed mode, so k 3 proves the clear
   task automatic run_mode(input logic self);
      logic [15:0] code;
      logic part;
      self_exp = self;
      pull_lvl = !self;
      rst_n = 1'b0;
      host_u.park(self);
      host_u.wait_cyc(3);
      rst_n = 1'b1;
      host_u.wait_cyc(10);
      check("mode", {17'h0_0000, self}, {17'h0_0000, self_clocked});
      check("echo enable", {17'h0_0000, self}, {17'h0_0000, echo_clk_oe_n});
      // the first result after reset is thrown away by the host
      host_u.start(1'b0);
      host_u.burst(self ? 18 : 16);
      host_u.wait_cyc(6);
      for (int k = 0; k < 8; k++) begin
         rng = xs(rng);
         code = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7fff : (k == 2) ? 16'hffff : rng[15:0];
         part = (k == 2) && !self;
         sample_code = code;
         host_u.start(k == 3);
         host_u.burst(part ? 8 : (self ? 18 : 16));
         host_u.wait_cyc(6);
         if (!part)
            check("word", frame_of(self, code),
               self ? host_u.cap_self_r : {2'h0, host_u.cap_echo_r});
         if (self) check("echo idle", 18'h0_0000, {17'h0_0000, echoed_clock_out});
      end
   endtask
   initial begin
      run_mode(1'b0);
      run_mode(1'b1);
      report_and_stop();
   end
   initial begin
      #500_000;
      num_errors++;
      report_and_stop();
   end
endmodule
